//--- hdl/qis_pkg.sv
// Constants, register map and state layout of the queued interrupt and supervision block
package qis_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_LEVEL = 8'h08;
	localparam logic [7:0] OFF_PEND = 8'h0C;
	localparam logic [7:0] OFF_FAULT = 8'h10;
	localparam logic [7:0] OFF_SANITY = 8'h14;
	localparam int ADDR_W = 8;

	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int LVL_VALID_BIT = 3;
	localparam int PEND_SRC_LSB = 8;
	localparam int NUM_LEVELS = 8;
	localparam int NUM_FAULTS = 5;

	// Fault bits, higher index means higher microlevel priority
	localparam int F_IODONE = 0;
	localparam int F_PARITY = 1;
	localparam int F_SANITY = 2;
	localparam int F_RESTART = 3;
	localparam int F_POWER = 4;

	// Reset values
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [3:0] LEVEL_RST = 4'h0;

	// Supervision timer: period in ms, clock rate in Hz, derived cycle count
	localparam int unsigned SANITY_MS = 400;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned SANITY_CYC = SANITY_MS * (CLK_HZ / 1000);
	localparam int WD_W = 26;

	// APB access phase, one-hot
	typedef enum logic [1:0]
	{
		ACC_IDLE = 2'b01,
		ACC_RESP = 2'b10
	} qis_acc_t;

	// Whole state of the block
	typedef struct packed
	{
		qis_acc_t acc;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic enable;
		logic [7:0] mask;
		logic [7:0] req;
		logic [3:0] level;
		logic [3:0] src_bus;
		logic irq_n;
		logic micro_irq;
		logic [2:0] micro_code;
		logic [WD_W-1:0] wd_cnt;
		logic [NUM_FAULTS-1:0] faults;
		logic parity_n;
		logic halt;
		logic init_vec;
		logic io_done_n;
		logic pf_seen;
		logic rst_prev_n;
	} qis_state_t;
endpackage

//--- hdl/qis_top.sv
// Queued high-level interrupt unit with microlevel fault supervision and APB registers
`timescale 1ns/1ps
module qis_top
#(
	parameter logic [qis_pkg::WD_W-1:0] SANITY_CYCLES = qis_pkg::WD_W'(qis_pkg::SANITY_CYC)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [qis_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] irq_level_n,
	input wire logic irq_take,
	output logic irq_to_processor_n,
	output logic [3:0] src_bus1,
	output logic micro_irq,
	output logic [2:0] micro_code,
	input wire logic mem_rd_strobe,
	input wire logic [15:0] mem_word,
	input wire logic mem_parity,
	output logic parity_n,
	input wire logic power_fail_n,
	input wire logic simulated_power_fail_n,
	output logic halt,
	input wire logic restart_request_n,
	output logic init_vector,
	input wire logic io_performing_n,
	output logic io_done_n
);

	qis_pkg::qis_state_t st_q;
	qis_pkg::qis_state_t st_d;

	logic acc_done;
	logic wr_en;
	logic [7:0] elig;
	logic [2:0] enc;
	logic take_ok;
	logic wd_restart;
	logic wd_expire;
	logic par_err;
	logic rst_fall;
	logic [qis_pkg::NUM_FAULTS-1:0] fault_set;
	logic [qis_pkg::NUM_FAULTS-1:0] fault_clr;

	// Index of the highest set bit; used for both the level and the fault encoders
	function automatic logic [2:0] hi_index(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (v[i])
			begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Levels strictly above the level latch; an empty latch blocks nothing
	function automatic logic [7:0] above(input logic [3:0] lvl);
		logic [7:0] m;
		m = 8'hFF;
		if (lvl[qis_pkg::LVL_VALID_BIT])
		begin
			for (int i = 0; i < 8; i++)
			begin
				m[i] = (3'(i) > lvl[2:0]);
			end
		end
		return m;
	endfunction

	// Bus strobes and event detection shared by the next-state logic
	assign acc_done = psel && penable && st_q.pready;
	assign wr_en = acc_done && pwrite && !st_q.pslverr;
	assign elig = st_q.req & above(st_q.level);
	assign enc = hi_index(elig);
	assign take_ok = irq_take && st_q.enable && (elig != 8'h00);
	assign wd_restart = wr_en && (paddr == qis_pkg::OFF_SANITY);
	assign wd_expire = (st_q.wd_cnt == SANITY_CYCLES - 1'b1);
	assign par_err = mem_rd_strobe && !(^{mem_word, mem_parity}); // Odd parity word
	assign rst_fall = st_q.rst_prev_n && !restart_request_n;

	// Fault sources; a clear in the same cycle as a set loses
	always_comb
	begin
		fault_set = '0;
		fault_set[qis_pkg::F_IODONE] = !io_performing_n;
		fault_set[qis_pkg::F_PARITY] = par_err;
		fault_set[qis_pkg::F_SANITY] = wd_expire && !wd_restart;
		fault_set[qis_pkg::F_RESTART] = rst_fall;
		fault_set[qis_pkg::F_POWER] = !power_fail_n || !simulated_power_fail_n;
		fault_clr = '0;
		if (wr_en && (paddr == qis_pkg::OFF_FAULT))
		begin
			fault_clr = pwdata[qis_pkg::NUM_FAULTS-1:0];
		end
		if (wd_restart)
		begin
			fault_clr[qis_pkg::F_SANITY] = 1'b1;
		end
	end

	// Next state of the whole block
	always_comb
	begin
		st_d = st_q;

		// APB slave: ready is raised for the second access cycle, the edge after it completes
		unique case (st_q.acc)
			qis_pkg::ACC_IDLE:
			begin
				st_d.pready = 1'b0;
				st_d.pslverr = 1'b0;
				if (psel && penable)
				begin
					st_d.acc = qis_pkg::ACC_RESP;
					st_d.pready = 1'b1;
					st_d.prdata = 32'h0000_0000;
					unique case (paddr)
						qis_pkg::OFF_CTRL: st_d.prdata[qis_pkg::CTRL_EN_BIT] = st_q.enable;
						qis_pkg::OFF_MASK: st_d.prdata[7:0] = st_q.mask;
						qis_pkg::OFF_LEVEL: st_d.prdata[3:0] = st_q.level;
						qis_pkg::OFF_PEND:
						begin
							st_d.prdata[7:0] = st_q.req;
							st_d.prdata[qis_pkg::PEND_SRC_LSB+:4] = st_q.src_bus;
						end
						qis_pkg::OFF_FAULT: st_d.prdata[qis_pkg::NUM_FAULTS-1:0] = st_q.faults;
						qis_pkg::OFF_SANITY: st_d.prdata[qis_pkg::WD_W-1:0] = st_q.wd_cnt;
						default: st_d.pslverr = 1'b1;
					endcase
				end
			end
			qis_pkg::ACC_RESP:
			begin
				st_d.acc = qis_pkg::ACC_IDLE;
				st_d.pready = 1'b0;
				st_d.pslverr = 1'b0;
			end
			default:
			begin
				st_d.acc = qis_pkg::ACC_IDLE;
				st_d.pready = 1'b0;
			end
		endcase

		// Register writes take effect only on the completing edge
		if (wr_en && (paddr == qis_pkg::OFF_CTRL))
		begin
			st_d.enable = pwdata[qis_pkg::CTRL_EN_BIT];
		end
		if (wr_en && (paddr == qis_pkg::OFF_MASK))
		begin
			st_d.mask = pwdata[7:0];
		end
		// Software restores the previous level on return so the old program resumes
		if (wr_en && (paddr == qis_pkg::OFF_LEVEL))
		begin
			st_d.level = pwdata[3:0];
		end

		// Request latch follows the active-low inputs; level one is the tape interface
		st_d.req = ~irq_level_n & ~st_q.mask;

		// Take: level code to source bus, serviced level into the latch
		if (take_ok)
		begin
			st_d.src_bus = {1'b0, enc};
			st_d.level = {1'b1, enc};
		end

		// Processor request; a take wins over a same-cycle software level write
		st_d.irq_n = !(st_q.enable && (elig != 8'h00));

		// Microlevel request and its vector code, highest fault first
		st_d.faults = (st_q.faults & ~fault_clr) | fault_set;
		st_d.micro_irq = !st_q.irq_n || (st_q.faults != '0);
		st_d.micro_code = hi_index({3'h0, st_q.faults});

		// Supervision timer saturates at the period so the fault is set only once until the next restart
		if (wd_restart)
		begin
			st_d.wd_cnt = '0;
		end
		else if (st_q.wd_cnt != SANITY_CYCLES)
		begin
			st_d.wd_cnt = st_q.wd_cnt + 1'b1;
		end

		// Parity microinterrupt is a one-cycle low pulse per bad word
		st_d.parity_n = !par_err;

		// Halt follows either power fail input with one flop of delay
		st_d.halt = !power_fail_n || !simulated_power_fail_n;

		// Restart vectors to initialization only after a power failure was seen
		st_d.rst_prev_n = restart_request_n;
		st_d.init_vec = rst_fall && st_q.pf_seen;
		if (!power_fail_n || !simulated_power_fail_n)
		begin
			st_d.pf_seen = 1'b1;
		end
		else if (rst_fall)
		begin
			st_d.pf_seen = 1'b0;
		end

		// I/O-performing forwarded as I/O-done
		st_d.io_done_n = io_performing_n;
	end

	// State register; reset gives constants only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q.acc <= qis_pkg::ACC_IDLE;
			st_q.pready <= 1'b0;
			st_q.pslverr <= 1'b0;
			st_q.prdata <= 32'h0000_0000;
			st_q.enable <= 1'b0;
			st_q.mask <= qis_pkg::MASK_RST;
			st_q.req <= 8'h00;
			st_q.level <= qis_pkg::LEVEL_RST;
			st_q.src_bus <= 4'h0;
			st_q.irq_n <= 1'b1;
			st_q.micro_irq <= 1'b0;
			st_q.micro_code <= 3'h0;
			st_q.wd_cnt <= '0;
			st_q.faults <= '0;
			st_q.parity_n <= 1'b1;
			st_q.halt <= 1'b0;
			st_q.init_vec <= 1'b0;
			st_q.io_done_n <= 1'b1;
			st_q.pf_seen <= 1'b0;
			st_q.rst_prev_n <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign irq_to_processor_n = st_q.irq_n;
	assign src_bus1 = st_q.src_bus;
	assign micro_irq = st_q.micro_irq;
	assign micro_code = st_q.micro_code;
	assign parity_n = st_q.parity_n;
	assign halt = st_q.halt;
	assign init_vector = st_q.init_vec;
	assign io_done_n = st_q.io_done_n;

	// Checks on the block's own outputs and state flops
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_irq_needs_enable: assert property (!st_q.enable |=> irq_to_processor_n)
		else $error("processor request active while disabled");
	a_irq_when_pending: assert property ((st_q.enable && elig != 8'h00) |=> !irq_to_processor_n)
		else $error("qualifying request not signalled");
	a_mask_blocks_req: assert property (1'b1 |=> ((st_q.req & $past(st_q.mask)) == 8'h00))
		else $error("masked level reached the request latch");
	a_take_src_bus: assert property (take_ok |=> (src_bus1 == {1'b0, $past(enc)}))
		else $error("source bus does not show taken level");
	a_block_lower: assert property ((st_q.level[3] && st_q.enable
		&& (st_q.req & above(st_q.level)) == 8'h00) |=> irq_to_processor_n)
		else $error("lower or equal level interrupted");
	a_pend_micro: assert property (!irq_to_processor_n |=> micro_irq)
		else $error("high-level request gave no microinterrupt");
	a_sanity_expire: assert property ((wd_expire && !wd_restart) |=> st_q.faults[qis_pkg::F_SANITY])
		else $error("supervision timeout not flagged");
	a_sanity_restart: assert property (wd_restart |=>
		(st_q.wd_cnt == '0 && !st_q.faults[qis_pkg::F_SANITY]))
		else $error("supervision timer not restarted");
	a_parity_pulse: assert property (par_err |=> !parity_n)
		else $error("parity error not signalled");
	a_halt_power: assert property (!power_fail_n |=> halt [*1])
		else $error("not halted under power fail");
	a_init_vector: assert property ((rst_fall && st_q.pf_seen) |=> init_vector ##1 !init_vector)
		else $error("restart did not vector to initialization");
	a_io_done: assert property ($fell(io_performing_n) |=> !io_done_n)
		else $error("I/O-done not forwarded");

	// Checks that do not just restate the next-state expressions, so a broken encoder shows
	a_enc_highest: assert property ((elig != 8'h00) |-> ((elig >> enc) == 8'h01))
		else $error("encoder did not pick the highest eligible level");
	a_take_level: assert property (take_ok |=> (st_q.level == {1'b1, $past(enc)}))
		else $error("taken level not written to the level latch");
	a_level_write: assert property ((wr_en && (paddr == qis_pkg::OFF_LEVEL) && !take_ok) |=>
		(st_q.level == $past(pwdata[3:0])))
		else $error("software level write lost");
	a_io_done_release: assert property ($rose(io_performing_n) |=> io_done_n)
		else $error("I/O-done not released");
	a_halt_sim_power: assert property (!simulated_power_fail_n |=> halt)
		else $error("not halted under simulated power fail");
	a_fault_micro: assert property ((st_q.faults != '0) |=> micro_irq)
		else $error("pending fault gave no microinterrupt");
	a_src_bus_hold: assert property (!take_ok |=> $stable(src_bus1))
		else $error("source bus changed without a take");
	a_parity_quiet: assert property (!par_err |=> parity_n)
		else $error("parity pulse without a bad word");
	a_timer_hold: assert property ((st_q.wd_cnt == SANITY_CYCLES && !wd_restart) |=>
		$stable(st_q.wd_cnt))
		else $error("expired supervision timer moved");
	a_restart_quiet: assert property (!rst_fall |=> !init_vector)
		else $error("initialization vector without restart");
	a_micro_power: assert property (st_q.faults[qis_pkg::F_POWER] |=>
		(micro_code == 3'(qis_pkg::F_POWER)))
		else $error("power fail not the top microlevel code");
	a_io_fault: assert property (!io_performing_n |=> st_q.faults[qis_pkg::F_IODONE])
		else $error("I/O-done status not recorded");

endmodule

//--- tb/qis_proc_model.sv
// Processor microsequencer model that takes high-level interrupts
`timescale 1ns/1ps
module qis_proc_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_to_processor_n,
	input wire logic [3:0] slow,
	output logic irq_take
);
	int wait_q;
	// Take one cycle after slow cycles of a low request; a short hold-off follows
	// so the request flop can settle before the next take, as a real sequencer would
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_take <= 1'h0;
			wait_q <= 0;
		end
		else if (irq_take)
		begin
			irq_take <= 1'h0;
			wait_q <= -2;
		end
		else if (irq_to_processor_n)
			wait_q <= 0;
		else if (wait_q >= int'(slow))
			irq_take <= 1'h1;
		else
			wait_q <= wait_q + 1;
	end
endmodule

//--- tb/qis_top_tb.sv
// Self-checking bench for the queued interrupt and supervision block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module qis_top_tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, irq_level_n = 8'hFF;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, irq_take, irq_n, micro_irq, parity_n, halt, init_vector;
	logic io_done_n, mem_rd_strobe = 1'h0, mem_parity = 1'h0, power_fail_n = 1'h1;
	logic simulated_power_fail_n = 1'h1, restart_request_n = 1'h1, io_performing_n = 1'h1;
	logic [3:0] src_bus1, slow = 4'h4;
	logic [2:0] micro_code;
	logic [15:0] mem_word = 16'h0001;
	int errors = 0, compares = 0, k;
	always #5 pclk = ~pclk;
	qis_top #(.SANITY_CYCLES(26'h14)) u_qis_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_level_n(irq_level_n), .irq_take(irq_take),
		.irq_to_processor_n(irq_n), .src_bus1(src_bus1), .micro_irq(micro_irq),
		.micro_code(micro_code), .mem_rd_strobe(mem_rd_strobe), .mem_word(mem_word),
		.mem_parity(mem_parity), .parity_n(parity_n), .power_fail_n(power_fail_n),
		.simulated_power_fail_n(simulated_power_fail_n), .halt(halt),
		.restart_request_n(restart_request_n), .init_vector(init_vector),
		.io_performing_n(io_performing_n), .io_done_n(io_done_n));
	qis_proc_model u_qis_proc_model (.pclk(pclk), .presetn(presetn),
		.irq_to_processor_n(irq_n), .slow(slow), .irq_take(irq_take));
	// One APB transfer; request held until pready is sampled, an idle cycle after
	// Only the watchdog bounds the wait, so a dead slave ends the run as a failure
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// Bounded wait for a taken level on the source bus
	task automatic wait_src(input logic [3:0] v);
		int n;
		n = 0;
		while (src_bus1 !== v && n < 30)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(src_bus1, v)
	endtask
	// Count init or parity pulses over a short window
	task automatic count_pulse(input logic sel, input int want);
		k = 0;
		repeat (6)
		begin
			@(posedge pclk);
			if ((sel ? init_vector : ~parity_n) === 1'h1)
				k++;
		end
		`CHK(k, want)
	endtask
	// One memory word presented for a single cycle
	task automatic mem_read(input logic par, input int want);
		mem_parity <= par;
		mem_rd_strobe <= 1'h1;
		@(posedge pclk);
		mem_rd_strobe <= 1'h0;
		count_pulse(1'h0, want);
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog; the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (4000) @(posedge pclk);
		errors++;
		$display("mismatch at %0t: run hung", $time);
		finish_test();
	end
	// Main sequence
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		`CHK({irq_n, halt, io_done_n, parity_n}, 4'hB);
		apb(1'h0, qis_pkg::OFF_MASK, 32'h0);
		`CHK(rd, {24'h0, qis_pkg::MASK_RST});
		apb(1'h0, qis_pkg::OFF_LEVEL, 32'h0);
		`CHK(rd, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000);
		apb(1'h1, qis_pkg::OFF_MASK, 32'h8);
		irq_level_n <= 8'hD7;
		repeat (5) @(posedge pclk);
		`CHK(irq_n, 1'h1);
		apb(1'h1, qis_pkg::OFF_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq_n, 1'h0);
		wait_src(4'h5);
		apb(1'h0, qis_pkg::OFF_LEVEL, 32'h0);
		`CHK(rd, 32'hD);
		irq_level_n <= 8'hD3;
		repeat (4) @(posedge pclk);
		`CHK(irq_n, 1'h1);
		slow <= 4'h0;
		irq_level_n <= 8'h53;
		wait_src(4'h7);
		irq_level_n <= 8'hD3;
		apb(1'h1, qis_pkg::OFF_LEVEL, 32'h0);
		wait_src(4'h5);
		irq_level_n <= 8'hFB;
		apb(1'h1, qis_pkg::OFF_LEVEL, 32'h0);
		wait_src(4'h2);
		irq_level_n <= 8'hFD;
		apb(1'h1, qis_pkg::OFF_LEVEL, 32'h0);
		wait_src(4'h1);
		apb(1'h0, qis_pkg::OFF_PEND, 32'h0);
		`CHK(rd, 32'h0000_0102);
		irq_level_n <= 8'hFF;
		// Software restart of the supervision timer
		apb(1'h1, qis_pkg::OFF_FAULT, 32'h1F);
		apb(1'h1, qis_pkg::OFF_SANITY, 32'h0);
		apb(1'h0, qis_pkg::OFF_FAULT, 32'h0);
		`CHK(rd[qis_pkg::F_SANITY], 1'h0);
		repeat (25) @(posedge pclk);
		apb(1'h0, qis_pkg::OFF_FAULT, 32'h0);
		`CHK(rd[qis_pkg::F_SANITY], 1'h1);
		`CHK({micro_irq, micro_code}, 4'hA);
		apb(1'h0, qis_pkg::OFF_SANITY, 32'h0);
		`CHK(rd, 32'h14);
		power_fail_n <= 1'h0;
		repeat (3) @(posedge pclk);
		`CHK(halt, 1'h1);
		power_fail_n <= 1'h1;
		simulated_power_fail_n <= 1'h0;
		repeat (3) @(posedge pclk);
		`CHK(halt, 1'h1);
		simulated_power_fail_n <= 1'h1;
		restart_request_n <= 1'h0;
		count_pulse(1'h1, 1);
		restart_request_n <= 1'h1;
		@(posedge pclk);
		restart_request_n <= 1'h0;
		count_pulse(1'h1, 0);
		io_performing_n <= 1'h0;
		repeat (2) @(posedge pclk);
		`CHK(io_done_n, 1'h0);
		io_performing_n <= 1'h1;
		repeat (2) @(posedge pclk);
		`CHK(io_done_n, 1'h1);
		mem_read(1'h0, 0);
		mem_read(1'h1, 1);
		apb(1'h0, qis_pkg::OFF_FAULT, 32'h0);
		`CHK(rd, 32'h1F);
		`CHK({micro_irq, micro_code}, 4'hC);
		finish_test();
	end
endmodule
